// >>> verilog/imdac_top.sv
// Operation
// - report multiplier lock as a logic level output
// - oscillator rate is sample rate times interpolation times prescaler
// - multiplier off, dual port: divided clock driven on capture pin; at 1x the code holds the pin high
// - control 02h bit 6 low selects dual-port input
// - dual port: both ports captured on rising edge of capture clock
// - control 02h bit 3 picks internal or external capture clock
// - capture clock runs at converter clock over interpolation factor
// - control 02h bit 6 high: interleaved samples on port one only
// - single port: interleaved clock at twice the capture rate; at 1x and 2x the code holds it high
// - steer select high writes I, low writes Q
// - control 02h bit 7 picks two's complement or offset binary
// - each path has three cascaded half-band interpolators, up to 8x
// - interpolators aim at 75 dB stopband rejection; the seven-tap filters here fall well short of it
// - mode bits 00 bypass modulators, pure dual interpolator
// - control 01h bits 7:6 select 1x, 2x, 4x or 8x
// - control 01h bit 2 high: independent real mix per path
// - mode 01 mixes at half converter rate, no image halving
// - mode 10 mixes at quarter rate, images halved
// - mode 11 mixes at eighth rate, images halved
// - interpolate first, then modulate at converter rate
// - multiplier on: capture at sample rate reference edge
// - control 01h bit 2 low couples modulators as complex mixer
// - control 01h bit 1 picks sign of the complex exponential
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module imdac_top (
  input  wire logic                     clk,
  input  wire logic                     rstn,
  input  wire imdac_pkg::imdac_apb_req_t apb_req,
  output imdac_pkg::imdac_apb_rsp_t      apb_rsp,
  input  wire logic [15:0]              port1_data,
  input  wire logic [15:0]              port2_data,
  input  wire logic                     channel_steer_select,
  input  wire logic                     capture_pin_in,
  output logic                          capture_pin_out,
  output logic                          capture_pin_oe,
  output logic                          pll_lock,
  output logic                          interleaved_port_clock,
  output imdac_pkg::imdac_iq_t           dac_out
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release

  logic [1:0] rst_sync_reg;
  logic       rst_ok;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_ok = rst_sync_reg[1];

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic tick_at(input logic [2:0] c, input logic [1:0] k);
    logic [2:0] m;
    m = 3'((4'h1 << k) - 4'h1);
    return (c & m) == 3'h0;
  endfunction

  function automatic logic [15:0] sat16(input logic signed [35:0] v);
    if (v > imdac_pkg::SAT_MAX) begin
      return 16'h7fff;
    end else if (v < imdac_pkg::SAT_MIN) begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction

  // odd phase of the half-band: (-a + 9b + 9c - d) / 16
  function automatic logic [15:0] hb_mid(input logic [15:0] a, input logic [15:0] b,
                                         input logic [15:0] c, input logic [15:0] d);
    logic signed [21:0] acc;
    acc = imdac_pkg::HB_MID_TAP * (22'($signed(b)) + 22'($signed(c)))
          - 22'($signed(a)) - 22'($signed(d));
    return sat16(36'(acc >>> imdac_pkg::HB_SHIFT));
  endfunction

  function automatic logic signed [17:0] cos8(input logic [2:0] e);
    unique case (e)
      3'h0:       return imdac_pkg::CAR_ONE;
      3'h1, 3'h7: return imdac_pkg::CAR_R2;
      3'h2, 3'h6: return 18'sh00000;
      3'h3, 3'h5: return -imdac_pkg::CAR_R2;
      3'h4:       return -imdac_pkg::CAR_ONE;
    endcase
  endfunction

  // offset binary flips the sign bit into two's complement
  function automatic logic [15:0] fmt(input logic [15:0] x, input logic offs);
    return offs ? {~x[15], x[14:0]} : x;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  imdac_pkg::imdac_state_t st_reg;
  imdac_pkg::imdac_state_t st_next;

  logic              [1:0] n;
  logic              [1:0] mode;
  logic              [1:0] presc;
  logic                    single;
  logic                    pll_en;
  logic                    ext_mode;
  logic                    in_tick;
  logic                    o_tick;
  logic                    cap_ev;
  logic                    ext_edge;
  logic                    dclk;
  logic                    oclk_c;
  logic              [2:0] e;
  logic signed      [17:0] ci;
  logic signed      [17:0] si;
  logic              [15:0] src;
  logic              [15:0] xi;
  logic              [15:0] xq;
  logic signed      [34:0] acc_i;
  logic signed      [34:0] acc_q;
  logic              [3:0] cfg;
  logic                    setup;
  logic                    wr;
  logic              [9:0] idx;
  logic              [6:0] ratio;
  logic             [31:0] rdata;
  logic                    hit;

  always_comb begin
    st_next = st_reg;
    n       = st_reg.ctrl1[imdac_pkg::CTRL1_INTERP_LO +: 2];
    mode    = st_reg.ctrl1[imdac_pkg::CTRL1_MOD_LO +: 2];
    presc   = st_reg.pllc[imdac_pkg::PLL_PRESC_LO +: 2];
    single  = st_reg.ctrl2[imdac_pkg::CTRL2_ONE_PORT];
    pll_en  = st_reg.pllc[imdac_pkg::PLL_ENABLE];
    ext_mode = st_reg.ctrl2[imdac_pkg::CTRL2_EXT_CLK] && !pll_en && !single;
    src     = 16'h0000;

    //////////////////////////////////////////////////////////////////////////
    // apb slave: one wait-free access cycle, answer registered at setup
    setup = apb_req.psel && !apb_req.penable;
    wr    = apb_req.psel && apb_req.penable && st_reg.rsp.pready && apb_req.pwrite;
    idx   = apb_req.paddr[11:2];
    ratio = 7'(8'h01 << (3'(n) + 3'(presc)));
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    if (apb_req.paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (idx == imdac_pkg::IDX_CTRL1) begin
      rdata[7:0] = st_reg.ctrl1;
    end else if (idx == imdac_pkg::IDX_CTRL2) begin
      rdata[7:0] = st_reg.ctrl2;
    end else if (idx == imdac_pkg::IDX_PLL) begin
      rdata[7:0] = st_reg.pllc;
    end else if (idx == imdac_pkg::IDX_STAT) begin
      rdata[imdac_pkg::STAT_LOCK] = st_reg.lock;
      rdata[imdac_pkg::STAT_RATIO_LO +: 7] = ratio;
    end else begin
      hit = 1'b0;
    end
    st_next.rsp.pready  = setup;
    st_next.rsp.pslverr = setup && !hit;
    st_next.rsp.prdata  = setup ? rdata : 32'h0000_0000;
    if (wr && hit) begin
      if (idx == imdac_pkg::IDX_CTRL1) begin
        st_next.ctrl1 = apb_req.pwdata[7:0];
      end else if (idx == imdac_pkg::IDX_CTRL2) begin
        st_next.ctrl2 = apb_req.pwdata[7:0];
      end else if (idx == imdac_pkg::IDX_PLL) begin
        st_next.pllc = apb_req.pwdata[7:0];
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // rate dividers: clk is the converter clock, slower rates are ticks
    st_next.cnt = st_reg.cnt + 3'h1;
    in_tick = tick_at(st_reg.cnt, n);
    o_tick  = (n == 2'h0) ? 1'b1 : tick_at(st_reg.cnt, n - 2'h1);
    // 1x cannot show a clock on a pin toggled from clk, so it stays high
    dclk    = (n == 2'h0) ? 1'b1 : ~st_reg.cnt[n - 2'h1];
    oclk_c  = (n <= 2'h1) ? 1'b1 : ~st_reg.cnt[n - 2'h2];

    //////////////////////////////////////////////////////////////////////////
    // sample capture
    st_next.ext_prev = capture_pin_in;
    ext_edge = capture_pin_in && !st_reg.ext_prev;
    cap_ev   = ext_mode ? ext_edge : in_tick;
    if (!single && cap_ev) begin
      st_next.cap[0] = fmt(port1_data, st_reg.ctrl2[imdac_pkg::CTRL2_OFFSET_BIN]);
      st_next.cap[1] = fmt(port2_data, st_reg.ctrl2[imdac_pkg::CTRL2_OFFSET_BIN]);
    end else if (single && o_tick) begin
      // port two is ignored in interleaved mode
      if (channel_steer_select) begin
        st_next.cap[0] = fmt(port1_data, st_reg.ctrl2[imdac_pkg::CTRL2_OFFSET_BIN]);
      end else begin
        st_next.cap[1] = fmt(port1_data, st_reg.ctrl2[imdac_pkg::CTRL2_OFFSET_BIN]);
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // half-band chain per channel; unused stages pass straight through
    // seven taps only: stopband falls well short of 75 dB, traded for area
    for (int ch = 0; ch < 2; ch++) begin
      for (int s = 0; s < 3; s++) begin
        src = (s == 0) ? st_reg.cap[ch] : st_reg.sout[ch][s-1];
        if (s < int'(n)) begin
          if (tick_at(st_reg.cnt, 2'(int'(n) - s - 1))) begin
            if (tick_at(st_reg.cnt, 2'(int'(n) - s))) begin
              st_next.taps[ch][s] = {st_reg.taps[ch][s][2:0], src};
              st_next.sout[ch][s] = st_reg.taps[ch][s][1];
            end else begin
              st_next.sout[ch][s] = hb_mid(st_reg.taps[ch][s][3], st_reg.taps[ch][s][2],
                                           st_reg.taps[ch][s][1], st_reg.taps[ch][s][0]);
            end
          end
        end else begin
          st_next.sout[ch][s] = src;
        end
      end
    end

    //////////////////////////////////////////////////////////////////////////
    // modulator at converter rate, after interpolation
    st_next.mode_prev = mode;
    st_next.mph = (mode != st_reg.mode_prev) ? 3'h0 : st_reg.mph + 3'h1;
    unique case (mode)
      imdac_pkg::MOD_HALF:  e = {st_reg.mph[0], 2'h0};
      imdac_pkg::MOD_QUART: e = {st_reg.mph[1:0], 1'b0};
      default:              e = st_reg.mph;
    endcase
    ci = cos8(e);
    si = st_reg.ctrl1[imdac_pkg::CTRL1_SIDEBAND] ? -cos8(e - 3'h2) : cos8(e - 3'h2);
    xi = st_reg.sout[0][2];
    xq = st_reg.sout[1][2];
    if (st_reg.ctrl1[imdac_pkg::CTRL1_REAL]) begin
      acc_i = 35'($signed(xi) * ci);
      acc_q = 35'($signed(xq) * ci);
    end else begin
      acc_i = 35'($signed(xi) * ci) - 35'($signed(xq) * si);
      acc_q = 35'($signed(xi) * si) + 35'($signed(xq) * ci);
    end
    if (mode == imdac_pkg::MOD_OFF) begin
      st_next.dac.i = xi;
      st_next.dac.q = xq;
    end else begin
      // round to nearest so that negated carrier phases give mirrored words
      st_next.dac.i = sat16(36'((acc_i + (35'sd1 <<< (imdac_pkg::CAR_SHIFT - 1)))
                                >>> imdac_pkg::CAR_SHIFT));
      st_next.dac.q = sat16(36'((acc_q + (35'sd1 <<< (imdac_pkg::CAR_SHIFT - 1)))
                                >>> imdac_pkg::CAR_SHIFT));
    end

    //////////////////////////////////////////////////////////////////////////
    // lock model: settles after a fixed time, drops on any rate change
    cfg = {n, presc};
    st_next.cfg_prev = cfg;
    if (!pll_en || cfg != st_reg.cfg_prev) begin
      st_next.lock_cnt = 12'h000;
      st_next.lock     = 1'b0;
    end else if (st_reg.lock_cnt < imdac_pkg::LOCK_CYC) begin
      st_next.lock_cnt = st_reg.lock_cnt + 12'h001;
    end else begin
      st_next.lock = 1'b1;
    end

    //////////////////////////////////////////////////////////////////////////
    // shared capture/lock pin and interleave clock
    if (pll_en) begin
      st_next.pin_oe  = 1'b1;
      st_next.pin_out = st_next.lock;
    end else if (!single && !ext_mode) begin
      st_next.pin_oe  = 1'b1;
      st_next.pin_out = dclk;
    end else begin
      st_next.pin_oe  = 1'b0;
      st_next.pin_out = 1'b0;
    end
    st_next.oclk = single ? oclk_c : 1'b0;
  end

  always_ff @(posedge clk or negedge rst_ok) begin
    if (!rst_ok) begin
      st_reg       <= '0;
      st_reg.ctrl1 <= imdac_pkg::CTRL1_RST;
      st_reg.ctrl2 <= imdac_pkg::CTRL2_RST;
      st_reg.pllc  <= imdac_pkg::PLL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign apb_rsp                = st_reg.rsp;
  assign capture_pin_out        = st_reg.pin_out;
  assign capture_pin_oe         = st_reg.pin_oe;
  assign pll_lock               = st_reg.lock;
  assign interleaved_port_clock = st_reg.oclk;
  assign dac_out                = st_reg.dac;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_ok);

  sequence tick_gap8_s;
    // a rate change inside the window restarts the spacing, so it excuses it
    ##1 (!in_tick || n != 2'h3) [*7] ##1 (in_tick || n != 2'h3);
  endsequence

  sequence lock_settle_s;
    !pll_lock [*8];
  endsequence

  apb_ready_a: assert property (setup |=> st_reg.rsp.pready)
    else $error("no ready after setup");
  lock_drop_a: assert property (!pll_en |=> !pll_lock)
    else $error("lock shown with multiplier off");
  lock_hold_a: assert property ($rose(pll_en) |=> lock_settle_s)
    else $error("lock reported before settling");
  capture_rate_a: assert property ((n == 2'h3 && in_tick) |-> tick_gap8_s)
    else $error("capture tick spacing wrong");
  pin_drive_a: assert property ((!single && !ext_mode && !pll_en) |=> capture_pin_oe)
    else $error("capture clock not driven");
  pin_float_a: assert property (ext_mode |=> !capture_pin_oe)
    else $error("pin driven in external mode");
  steer_i_a: assert property ((single && o_tick && channel_steer_select) |=>
      st_reg.cap[0] == fmt($past(port1_data), st_reg.ctrl2[imdac_pkg::CTRL2_OFFSET_BIN]))
    else $error("steered word missed I");
  phase_restart_a: assert property ((mode != st_reg.mode_prev) |=> st_reg.mph == 3'h0)
    else $error("carrier phase not restarted");
  bypass_pass_a: assert property ((mode == imdac_pkg::MOD_OFF) |=>
      dac_out.i == $past(st_reg.sout[0][2]))
    else $error("bypass altered samples");
  half_sign_a: assert property ((mode == imdac_pkg::MOD_HALF
      && st_reg.ctrl1[imdac_pkg::CTRL1_REAL]
      && st_reg.mph[0] && mode == st_reg.mode_prev && st_reg.sout[0][2] == 16'h1000)
      |=> dac_out.i == 16'hf000)
    else $error("half rate sign wrong");

endmodule // imdac_top

`default_nettype wire

// >>> include/imdac_pkg.sv
package imdac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_CTRL1 = 10'h001;
  localparam logic [9:0] IDX_CTRL2 = 10'h002;
  localparam logic [9:0] IDX_PLL   = 10'h003;
  localparam logic [9:0] IDX_STAT  = 10'h004;

  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  localparam logic [7:0] PLL_RST   = 8'h00;

  // control 01h fields
  localparam int CTRL1_INTERP_LO = 6;
  localparam int CTRL1_MOD_LO    = 4;
  localparam int CTRL1_REAL      = 2;
  localparam int CTRL1_SIDEBAND  = 1;
  // control 02h fields
  localparam int CTRL2_OFFSET_BIN = 7;
  localparam int CTRL2_ONE_PORT   = 6;
  localparam int CTRL2_EXT_CLK    = 3;
  // multiplier control fields
  localparam int PLL_ENABLE    = 7;
  localparam int PLL_PRESC_LO  = 0;
  // status fields
  localparam int STAT_LOCK     = 0;
  localparam int STAT_RATIO_LO = 8;

  localparam logic [1:0] MOD_OFF    = 2'h0;
  localparam logic [1:0] MOD_HALF   = 2'h1;
  localparam logic [1:0] MOD_QUART  = 2'h2;
  localparam logic [1:0] MOD_EIGHTH = 2'h3;

  // multiplier settle time before lock is reported
  localparam int CLK_MHZ      = 200;
  localparam int PLL_LOCK_NS  = 10000;
  localparam int LOCK_CYC_INT = (PLL_LOCK_NS * CLK_MHZ + 999) / 1000;
  localparam logic [11:0] LOCK_CYC = 12'(LOCK_CYC_INT);

  // carrier values in q15, one is 2^15
  localparam logic signed [17:0] CAR_ONE = 18'sh08000;
  localparam logic signed [17:0] CAR_R2  = 18'sh05a82;
  localparam int CAR_SHIFT = 15;
  localparam logic signed [21:0] HB_MID_TAP = 22'sh000009;
  localparam int HB_SHIFT = 4;
  localparam logic signed [35:0] SAT_MAX = 36'sh000007fff;
  localparam logic signed [35:0] SAT_MIN = -36'sh000008000;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } imdac_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } imdac_apb_rsp_t;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } imdac_iq_t;

  typedef struct packed {
    imdac_apb_rsp_t              rsp;
    logic [7:0]                  ctrl1;
    logic [7:0]                  ctrl2;
    logic [7:0]                  pllc;
    logic [2:0]                  cnt;
    logic                        ext_prev;
    logic [1:0][15:0]            cap;
    logic [1:0][2:0][3:0][15:0]  taps;
    logic [1:0][2:0][15:0]       sout;
    logic [2:0]                  mph;
    logic [1:0]                  mode_prev;
    logic [3:0]                  cfg_prev;
    logic [11:0]                 lock_cnt;
    logic                        lock;
    logic                        pin_out;
    logic                        pin_oe;
    logic                        oclk;
    imdac_iq_t                   dac;
  } imdac_state_t;

endpackage

// >>> dv/imdac_bbp_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// baseband source: dual words, or I/Q interleaved on port one
module imdac_bbp_model (
  input  wire logic        clk,
  input  wire logic        single,
  input  wire logic        ext_en,
  input  wire logic        port_clk,
  input  wire logic [15:0] i_val,
  input  wire logic [15:0] q_val,
  output logic [15:0]      port1_data,
  output logic [15:0]      port2_data,
  output logic             steer,
  output logic             ext_clk
);
  logic pc_prev;
  logic pc_prev2;
  initial begin
    {port1_data, port2_data, steer, ext_clk, pc_prev, pc_prev2} = '0;
  end
  always @(posedge clk) begin
    pc_prev  <= port_clk;
    pc_prev2 <= pc_prev;
    // external capture clock at clk/2, still when unused
    ext_clk <= ext_en ? ~ext_clk : 1'b0;
    if (!single) begin
      port1_data <= i_val;
      port2_data <= q_val;
    end else begin
      // port two unused here, so it toggles every cycle to expose any use
      port2_data <= ~port2_data;
      if (port_clk && (!pc_prev || pc_prev2)) begin
        steer      <= ~steer;
        port1_data <= steer ? q_val : i_val;
      end
    end
  end
endmodule // imdac_bbp_model
`default_nettype wire

// >>> dv/imdac_top_test.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module imdac_top_test;
  logic                      clk = 1'b0;
  logic                      rstn = 1'b0;
  imdac_pkg::imdac_apb_req_t req = '0;
  imdac_pkg::imdac_apb_rsp_t rsp;
  imdac_pkg::imdac_iq_t      dac;
  logic [15:0]               p1, p2, si[16], sq[16];
  logic [15:0]               iv = 16'h0000;
  logic [15:0]               qv = 16'h0000;
  logic                      single = 1'b0;
  logic                      ext_en = 1'b0;
  logic                      steer, ext_clk, pin_out, pin_oe, pin_in, lock, ipc, err;
  logic [31:0]               rd;
  int                        error_cnt = 0;
  int                        checks = 0;
  int                        ca, ia;

  always #2.5 clk = ~clk;
  // shared pin: the device wins while it drives, else the source's clock
  assign pin_in = pin_oe ? pin_out : ext_clk;

  imdac_top i_imdac_top (.clk(clk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp),
    .port1_data(p1), .port2_data(p2), .channel_steer_select(steer),
    .capture_pin_in(pin_in), .capture_pin_out(pin_out), .capture_pin_oe(pin_oe),
    .pll_lock(lock), .interleaved_port_clock(ipc), .dac_out(dac));
  imdac_bbp_model i_imdac_bbp_model (.clk(clk), .single(single), .ext_en(ext_en),
    .port_clk(ipc), .i_val(iv), .q_val(qv), .port1_data(p1), .port2_data(p2),
    .steer(steer), .ext_clk(ext_clk));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.psel    <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite  <= wr;
    req.paddr   <= a;
    req.pwdata  <= d;
    @(posedge clk);
    req.penable <= 1'b1;
    // only the watchdog ends a wait that never sees ready
    do @(posedge clk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0);
    check(rd, e);
    check(err, ee);
  endtask

  task automatic cfg(input logic [7:0] c1, input logic [7:0] c2);
    apb(1'b1, 12'h004, {24'h0, c1});
    apb(1'b1, 12'h008, {24'h0, c2});
    repeat (100) @(posedge clk);
  endtask

  // rising edges of the capture and interleave clocks over 64 cycles
  task automatic measure(output int c, output int p);
    logic a0, b0;
    c = 0;
    p = 0;
    @(posedge clk);
    a0 = pin_out;
    b0 = ipc;
    repeat (64) begin
      @(posedge clk);
      if (pin_out && !a0) c++;
      if (ipc && !b0) p++;
      a0 = pin_out;
      b0 = ipc;
    end
  endtask

  task automatic grab;
    for (int n = 0; n < 16; n++) begin
      @(posedge clk);
      si[n] = dac.i;
      sq[n] = dac.q;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(12'h004, 32'h0, 1'b0);
    rd_chk(12'h008, 32'h0, 1'b0);
    rd_chk(12'h020, 32'h0, 1'b1);
    rd_chk(12'h005, 32'h0, 1'b1);
    apb(1'b1, 12'h004, 32'h0000_00d4);
    rd_chk(12'h004, 32'h0000_00d4, 1'b0);
    iv <= 16'h1000;
    qv <= 16'h2000;
    for (int k = 0; k < 4; k++) begin
      cfg(8'(k << 6), 8'h00);
      measure(ca, ia);
      check(ca, (k == 0) ? 0 : (64 >> k));
      check(pin_oe, 1'b1);
      check(ia, 0);
      check(dac.i, 16'h1000);
      check(dac.q, 16'h2000);
    end
    iv <= 16'h9000;
    qv <= 16'h2000;
    cfg(8'h00, 8'h80);
    check(dac.i, 16'h1000);
    check(dac.q, 16'ha000);
    single <= 1'b1;
    iv <= 16'h1234;
    qv <= 16'h4321;
    cfg(8'h00, 8'h40);
    check(dac.i, 16'h1234);
    check(dac.q, 16'h4321);
    for (int k = 2; k < 4; k++) begin
      cfg(8'(k << 6), 8'h40);
      measure(ca, ia);
      check(ia, 64 >> (k - 1));
    end
    single <= 1'b0;
    ext_en <= 1'b1;
    iv <= 16'h0777;
    cfg(8'h40, 8'h08);
    check(pin_oe, 1'b0);
    check(dac.i, 16'h0777);
    ext_en <= 1'b0;
    iv <= 16'h1000;
    qv <= 16'h0000;
    // half rate at 1x and 2x: sign flips every converter cycle
    for (int m = 0; m < 2; m++) begin
      cfg(m ? 8'h54 : 8'h14, 8'h00);
      grab();
      check(si[0] === 16'h1000 || si[0] === 16'hf000, 1'b1);
      for (int n = 1; n < 16; n++) check(si[n], 16'(16'h0 - si[n-1]));
    end
    cfg(8'h24, 8'h00);
    grab();
    for (int n = 0; n < 14; n++) begin
      check(si[n+2], 16'(16'h0 - si[n]));
      check((si[n] === 16'h0) != (si[n+1] === 16'h0), 1'b1);
    end
    cfg(8'h34, 8'h00);
    grab();
    ca = 0;
    for (int n = 0; n < 8; n++) begin
      check(si[n+4], 16'(16'h0 - si[n]));
      if (si[n] === 16'h0b50) ca++;
    end
    check(ca, 2);
    // complex quarter rate: sine leg lands on the Q output
    for (int s = 0; s < 2; s++) begin
      cfg(s ? 8'h22 : 8'h20, 8'h00);
      grab();
      ca = 0;
      for (int n = 1; n < 16; n++) begin
        if (si[n-1] === 16'h1000) begin
          ca++;
          check(sq[n], s ? 16'hf000 : 16'h1000);
        end
      end
      check(ca > 0, 1'b1);
    end
    apb(1'b1, 12'h00c, 32'h0000_0081);
    repeat (10) @(posedge clk);
    check(lock, 1'b0);
    repeat (imdac_pkg::LOCK_CYC_INT + 50) @(posedge clk);
    check(lock, 1'b1);
    check(pin_out, 1'b1);
    rd_chk(12'h010, 32'h0000_0201, 1'b0);
    report_and_stop();
  end

  // whole run is near 4200 cycles
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end
endmodule // imdac_top_test
`default_nettype wire
